// *** core/ahs_map.svh ***
`ifndef AHS_MAP_SVH
`define AHS_MAP_SVH
// Behaviour
// - HTRANS codes IDLE 00 BUSY 01 NONSEQ 10 SEQ 11
// - SEQ beats repeat previous control
// - SEQ address is previous plus size
// - Wrapping bursts exist but never issued
// - First beat and singles are NONSEQ
// - Granted master without work drives IDLE
// - Slave answers IDLE zero-wait OKAY
// - BUSY may pause a running burst
// - BUSY already shows next beat
// - Announced beat after BUSY always follows
// - Slave answers BUSY zero-wait OKAY
// - HBURST only SINGLE or INCR
// - Bursts are undefined-length incrementing
// - Bursts never cross 1 Kbyte boundary
// - Single may be one-beat INCR
// - Every beat aligned to its size
// - Slave stalls with HREADY low
// - HREADY low extends, high completes
// - Sizes only byte, halfword, word
`define AHS_TRANS_IDLE   2'h0
`define AHS_TRANS_BUSY   2'h1
`define AHS_TRANS_NONSEQ 2'h2
`define AHS_TRANS_SEQ    2'h3
`define AHS_BURST_SINGLE 3'h0
`define AHS_BURST_INCR   3'h1
`define AHS_SIZE_BYTE    3'h0
`define AHS_SIZE_HALF    3'h1
`define AHS_SIZE_WORD    3'h2
`define AHS_KB_MSB       9
`define AHS_RESP_OKAY    2'h0
`define AHS_SLV_WAITS    2'h1
`endif

// *** core/ahs_pkg.sv ***
`default_nettype none
package ahs_pkg;
  typedef logic [1:0]  ahs_trans_t;
  typedef logic [2:0]  ahs_size_t;
  typedef logic [31:0] ahs_addr_t;
  typedef enum logic [1:0] {
    AHS_IDLE,
    AHS_RUN,
    AHS_PAUSE
  } ahs_mst_e;
endpackage
`default_nettype wire

// *** core/ahs_if.sv ***
`default_nettype none
interface ahs_if (
  input wire logic clk,
  input wire logic rst_n
);
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hburst;
  logic [2:0]  hsize;
  logic        hwrite;
  logic        hready;
  logic [1:0]  hresp;
  modport mst (
    input  clk, rst_n, hready, hresp,
    output haddr, htrans, hburst, hsize, hwrite
  );
  modport slv (
    input  clk, rst_n, haddr, htrans, hburst, hsize, hwrite,
    output hready, hresp
  );
endinterface
`default_nettype wire

// *** core/ahs_slave_end.sv ***
`include "ahs_map.svh"
`default_nettype none
module ahs_slave_end
  import ahs_pkg::*;
(
  // Bus
  ahs_if.slv   bus,
  // User
  input  wire logic [1:0] wait_cfg,
  output logic            beat_done,
  output logic [31:0]     beat_addr
);
  logic        dp_act_r;
  logic [1:0]  wcnt_r;
  logic        ready_w;
  logic        new_beat_w;

  // IDLE and BUSY never open a data phase
  assign new_beat_w = bus.hready & bus.htrans[1];
  assign ready_w    = ~dp_act_r | (wcnt_r == 2'h0);
  assign bus.hready = ready_w;
  assign bus.hresp  = `AHS_RESP_OKAY;
  assign beat_done  = dp_act_r & ready_w;

  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      dp_act_r  <= 1'b0;
      wcnt_r    <= 2'h0;
      beat_addr <= 32'h0;
    end else if (ready_w) begin
      dp_act_r <= new_beat_w;
      wcnt_r   <= wait_cfg;
      if (new_beat_w) begin
        beat_addr <= bus.haddr;
      end
    end else begin
      wcnt_r <= wcnt_r - 2'h1;
    end
  end
endmodule
`default_nettype wire

// *** core/ahs_master_end.sv ***
`include "ahs_map.svh"
`default_nettype none
module ahs_master_end
  import ahs_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Bus
  ahs_if.mst               bus,
  // Request: a run of beats starting at req_addr aligned down to the beat size
  input  wire logic        req_valid,
  input  wire logic [31:0] req_addr,
  input  wire logic [2:0]  req_size,
  input  wire logic        req_write,
  input  wire logic [7:0]  req_beats,
  input  wire logic        stall,
  output logic             req_ready,
  // Status
  output logic             busy_o
);
  ahs_mst_e    st_r;
  logic [31:0] addr_r;
  logic [1:0]  trans_r;
  logic [2:0]  burst_r;
  logic [2:0]  size_r;
  logic        write_r;
  logic [7:0]  left_r;

  function automatic logic [31:0] step(input logic [2:0] sz);
    case (sz)
      `AHS_SIZE_HALF: step = 32'h2;
      `AHS_SIZE_WORD: step = 32'h4;
      default:        step = 32'h1;
    endcase
  endfunction

  function automatic logic [2:0] legal_size(input logic [2:0] sz);
    legal_size = (sz > `AHS_SIZE_WORD) ? `AHS_SIZE_WORD : sz;
  endfunction

  function automatic logic [31:0] align(input logic [31:0] a,
                                        input logic [2:0] sz);
    case (sz)
      `AHS_SIZE_HALF: align = {a[31:1], 1'b0};
      `AHS_SIZE_WORD: align = {a[31:2], 2'h0};
      default:        align = a;
    endcase
  endfunction

  logic [2:0]  rsz_w;
  logic [31:0] next_addr_w;
  logic        cross_w;
  logic        more_w;
  logic        adv_w;
  logic        take_w;
  logic        edge_w;

  assign rsz_w       = legal_size(req_size);
  assign next_addr_w = addr_r + step(size_r);
  // Next beat would leave the current 1 Kbyte region
  assign cross_w     = next_addr_w[31:`AHS_KB_MSB+1] !=
                       addr_r[31:`AHS_KB_MSB+1];
  assign more_w      = left_r != 8'h0;
  // Next beat opens a fresh 1 Kbyte region
  assign edge_w      = (st_r == AHS_RUN) ? cross_w
                       : (addr_r[`AHS_KB_MSB:0] == 10'h0);
  assign adv_w       = bus.hready;
  assign req_ready   = adv_w & (st_r == AHS_IDLE |
                       (st_r == AHS_RUN & ~more_w));
  assign take_w      = req_valid & req_ready & (req_beats != 8'h0);
  assign busy_o      = st_r != AHS_IDLE;

  assign bus.haddr  = addr_r;
  assign bus.htrans = trans_r;
  assign bus.hburst = burst_r;
  assign bus.hsize  = size_r;
  assign bus.hwrite = write_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r    <= AHS_IDLE;
      addr_r  <= 32'h0;
      trans_r <= `AHS_TRANS_IDLE;
      burst_r <= `AHS_BURST_SINGLE;
      size_r  <= `AHS_SIZE_BYTE;
      write_r <= 1'b0;
      left_r  <= 8'h0;
    end else if (adv_w) begin
      if (take_w) begin
        // Fresh burst always opens NONSEQ at an aligned address
        st_r    <= AHS_RUN;
        addr_r  <= align(req_addr, rsz_w);
        trans_r <= `AHS_TRANS_NONSEQ;
        burst_r <= (req_beats == 8'h1) ? `AHS_BURST_SINGLE
                                       : `AHS_BURST_INCR;
        size_r  <= rsz_w;
        write_r <= req_write;
        left_r  <= req_beats - 8'h1;
      end else begin
        case (st_r)
          AHS_RUN, AHS_PAUSE: begin
            if (!more_w) begin
              st_r    <= AHS_IDLE;
              trans_r <= `AHS_TRANS_IDLE;
            end else begin
              // BUSY already carries the next beat; no cancel path
              addr_r  <= (st_r == AHS_RUN) ? next_addr_w
                                           : addr_r;
              st_r    <= stall ? AHS_PAUSE : AHS_RUN;
              left_r  <= stall ? left_r : left_r - 8'h1;
              if (stall) begin
                // BUSY at a region edge would stretch the burst across it
                trans_r <= edge_w ? `AHS_TRANS_IDLE
                                  : `AHS_TRANS_BUSY;
              end else if (edge_w) begin
                trans_r <= `AHS_TRANS_NONSEQ;
              end else begin
                trans_r <= `AHS_TRANS_SEQ;
              end
              if (st_r == AHS_RUN && cross_w) begin
                // Continue past boundary as a new burst
                burst_r <= `AHS_BURST_INCR;
              end
            end
          end
          default: begin
            st_r    <= AHS_IDLE;
            trans_r <= `AHS_TRANS_IDLE;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/ahs_properties.sv ***
`default_nettype none
module ahs_properties (
  // Bus wires
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic [2:0]  hburst,
  input wire logic [2:0]  hsize,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [1:0]  hresp
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_codes; hburst <= 3'h1 && hsize <= 3'h2; endproperty
  property p_align;
    htrans[1] |-> (haddr & ((32'h1 << hsize) - 32'h1)) == 32'h0;
  endproperty
  property p_step; htrans == 2'h3 && $past(htrans) >= 2'h2 && $past(hready)
    |-> haddr == $past(haddr) + (32'h1 << hsize); endproperty
  property p_ctrl;
    htrans == 2'h3 |-> $stable(hsize) && $stable(hwrite) && hburst == 3'h1;
  endproperty
  property p_kb; htrans[0] |-> haddr[9:0] != 10'h0; endproperty
  property p_next;
    htrans == 2'h1 && hready |=> htrans[0] && $stable(haddr);
  endproperty
  property p_first; htrans[0] |-> $past(htrans) != 2'h0; endproperty
  property p_busy; htrans == 2'h1 |=> htrans != 2'h0; endproperty
  property p_hold;
    !$past(hready) |-> $stable(haddr) && $stable(htrans);
  endproperty
  property p_zw; $past(htrans) <= 2'h1 && $past(hready)
    |-> hready && hresp == 2'h0; endproperty
  a_codes: assert property (p_codes) else $error("bad code");
  a_align: assert property (p_align) else $error("unaligned");
  a_step: assert property (p_step) else $error("bad step");
  a_ctrl: assert property (p_ctrl) else $error("ctrl moved");
  a_kb: assert property (p_kb) else $error("kb crossed");
  a_first: assert property (p_first) else $error("no nonseq");
  a_busy: assert property (p_busy) else $error("beat dropped");
  a_next: assert property (p_next) else $error("busy beat moved");
  a_hold: assert property (p_hold) else $error("not held");
  a_zw: assert property (p_zw) else $error("idle waited");
  c_busy: cover property (htrans == 2'h1);
  c_wait: cover property (!hready && htrans == 2'h3);
  c_kb: cover property (htrans == 2'h2 && haddr[9:0] == 10'h0);
endmodule
`default_nettype wire

// *** testbench/ahb_master_transfer_sequencer_tb.sv ***
`default_nettype none
module ahb_master_transfer_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, req_valid, req_write, stall, req_ready;
  logic        busy_o, beat_done;
  logic [31:0] req_addr, beat_addr, a;
  logic [2:0]  req_size;
  logic [7:0]  req_beats;
  logic [1:0]  wait_cfg;
  logic [31:0] exp_q[$];
  int          n_mismatch, checks_done, cyc, seed;
  ahs_if ahs_if_i (.clk(clk), .rst_n(rst_n));
  ahs_master_end ahs_master_end_i (.clk(clk), .rst_n(rst_n), .bus(ahs_if_i),
    .req_valid(req_valid), .req_addr(req_addr), .req_size(req_size),
    .req_write(req_write), .req_beats(req_beats), .stall(stall),
    .req_ready(req_ready), .busy_o(busy_o));
  ahs_slave_end ahs_slave_end_i (.bus(ahs_if_i), .wait_cfg(wait_cfg),
    .beat_done(beat_done), .beat_addr(beat_addr));
  ahs_properties ahs_properties_i (.clk(clk), .rst_n(rst_n),
    .haddr(ahs_if_i.haddr), .htrans(ahs_if_i.htrans),
    .hburst(ahs_if_i.hburst), .hsize(ahs_if_i.hsize),
    .hwrite(ahs_if_i.hwrite), .hready(ahs_if_i.hready),
    .hresp(ahs_if_i.hresp));
  task automatic give_verdict();
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Expected beats: aligned-down start, size clamped to word
  task automatic req(input logic [31:0] ad, input logic [2:0] sz,
                     input logic [7:0] n);
    logic [2:0] s;
    s = (sz > 3'h2) ? 3'h2 : sz;
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_addr = ad;
    req_size = sz;
    req_beats = n;
    req_write = 1'($random(seed));
    wait_cfg = 2'($random(seed));
    @(negedge clk);
    while (!(req_ready && ahs_if_i.hready)) @(negedge clk);
    for (int i = 0; i < n; i++)
      exp_q.push_back((ad & ~((32'h1 << s) - 32'h1)) + (32'(i) << s));
    @(posedge clk);
    #1;
    req_valid = 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Random pauses exercise BUSY mid-burst
  always @(posedge clk) begin
    #1;
    stall = ($random(seed) & 3) == 0;
  end
  always @(negedge clk) if (rst_n && beat_done) begin
    chk(beat_addr, exp_q.size() ? exp_q.pop_front() : 'x);
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    seed = 32'h6A57;
    {rst_n, req_valid, req_write, req_addr} = '0;
    {req_size, req_beats, wait_cfg} = '0;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    req(32'h3FE, 3'h1, 8'h0);
    req(32'h13, 3'h2, 8'h1);
    // Starts near a 1 KB edge so long runs must restart
    for (int k = 0; k < 24; k++) begin
      a = $random(seed);
      a[9:4] = 6'h3F;
      req(a, k[2:0] % 3'h4, 8'h1 + {2'h0, 6'($random(seed))});
    end
    while (exp_q.size() != 0) @(negedge clk);
    repeat (4) @(negedge clk);
    chk({31'h0, busy_o}, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
